// >>> hw/mcx_executor.sv
/*
 * Instruction executor of a small 8-bit core, reached over Avalon-MM.
 * Software writes an instruction word to the instruction register and
 * the core executes it against its own register pages and EEPROM.
 * Assumes bus signals synchronous to clk_in; one request at a time.
 */
// The address map and register access over Avalon-MM were chosen for this implementation.
//
// Contract
// - destination bit 0 writes work register, 1 writes addressed register
// - carry is 1 on add carry or subtract without borrow, else 0
// - subtract is register plus complemented work plus one or carry
// - add with carry sums register, work and carry in one cycle
// - plain add sums work and register without carry, one cycle
// - direct operands address register page 0x00 to 0x3F, six bits
// - one-cycle store and load with secondary page 0x5 to 0xF
// - one-cycle store and load with third page 0x0 to 0x13
// - bit test skips next instruction, two cycles when skipping
// - increment or decrement with skip skips on zero result, flags untouched
// - halt takes one cycle, clears power-down flag, sets timeout flag
// - watchdog clear restarts counter, sets both power and timeout flags
// - watchdog expiry clears timeout flag; it is set after power-up
// - jump through work register takes two cycles
// - call through work register pushes return address, two cycles
// - EEPROM read loads byte at address register into data register
// - EEPROM write stores data register at address register
// - EEPROM write instruction accepted only after the serial unlock key sequence; bus writes to the EEPROM page need no key
// - decimal adjust corrects work register to BCD, only carry changes
// - decoder recognises every documented opcode
// - wake_in with interrupts enabled vectors to 0x008, else continues
`timescale 1ns/1ps

module mcx_executor
   import mcx_pkg::*;
#(
   parameter int WDT_LIMIT   = WDT_CYCLES,
   parameter int STACK_DEPTH = 4,
   parameter int EE_DEPTH    = 64
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              sys_rst_in,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0] avm_address_in,
   input  wire logic              avm_read_in,
   input  wire logic              avm_write_in,
   input  wire logic [31:0]       avm_writedata_in,
   output logic [31:0]            avm_readdata_out,
   output logic                   avm_waitrequest_out,
   // Core status
   input  wire logic              wake_in,
   output logic                   halted_out
);

   initial begin
      if (STACK_DEPTH < 2 || STACK_DEPTH > 16 || EE_DEPTH < 2 || EE_DEPTH > 256 ||
          WDT_LIMIT < 2)
         $error("mcx_executor: unsupported parameter value");
   end

   localparam int SP_W  = $clog2(STACK_DEPTH);
   localparam int EEA_W = $clog2(EE_DEPTH);

   // State
   logic [7:0]      work_reg, eea_reg, eed_reg, t0md_reg;
   logic            c_reg, dc_reg, z_reg, pd_n_reg, to_n_reg, gie_reg, halt_reg;
   logic [1:0]      unlock_reg;
   logic [PC_W-1:0] pc_reg;
   logic [SP_W-1:0] sp_reg;
   logic [1:0]      busy_reg;
   logic [31:0]     wdt_reg;
   logic [15:0]     ins_reg;
   logic            wait_reg;
   logic [31:0]     rdata_reg;
   logic [7:0]      rpage [R_PAGE_SIZE];
   logic [7:0]      fpage [16];
   logic [7:0]      spage [S_PAGE_SIZE];
   logic [7:0]      ee_mem [EE_DEPTH];
   logic [PC_W-1:0] stack [STACK_DEPTH];

   // Bus decode
   wire logic [3:0] bus_page   = avm_address_in[11:8];
   wire logic [5:0] bus_idx    = avm_address_in[7:2];
   wire logic       bus_req    = (avm_read_in | avm_write_in) & wait_reg;
   wire logic       is_ins_wr  = avm_write_in & bus_page == PAGE_CTRL & bus_idx == IDX_INSTR;
   // Instruction writes stall while executing or halted, back-pressure to the master
   wire logic       bus_go     = bus_req & ~(is_ins_wr & (busy_reg != 2'h0 | halt_reg));
   wire logic       ins_go     = bus_go & is_ins_wr;
   wire logic       wr_go      = bus_go & avm_write_in & ~is_ins_wr;
   wire logic       f_ok_bus   = bus_idx[3:0] >= F_PAGE_LO & bus_idx[5:4] == 2'h0;
   wire logic       s_ok_bus   = bus_idx < 6'(S_PAGE_SIZE);
   wire logic       ee_ok_bus  = 32'(bus_idx) < EE_DEPTH;

   // Instruction fields
   wire logic [15:0] ins       = avm_writedata_in[15:0];
   wire mcx_op_t     op        = mcx_op_t'(ins[15:10]);
   wire logic [5:0]  r_idx     = ins[5:0];
   wire logic        d_bit     = ins[6];
   wire logic [2:0]  b_idx     = ins[9:7];
   wire logic [7:0]  imm       = ins[7:0];
   wire logic [3:0]  f_idx     = ins[3:0];
   wire logic [4:0]  s_idx     = ins[4:0];
   wire logic        f_ok      = f_idx >= F_PAGE_LO && f_idx <= F_PAGE_HI;
   wire logic        s_ok      = 6'(s_idx) < 6'(S_PAGE_SIZE);
   wire logic [7:0]  rv        = rpage[r_idx];
   wire logic [PC_W-1:0] pc_inc  = pc_reg + 10'h001;
   wire logic [PC_W-1:0] pc_skip = pc_reg + 10'h002;
   wire logic [SP_W-1:0] sp_top  = sp_reg - SP_W'(1);

   // Adder shared by add, subtract and compare
   wire logic imm_op   = op == OP_ADD_I | op == OP_SUB_I | op == OP_ADC_I | op == OP_SBC_I;
   wire logic sub_op   = op == OP_SUB_R | op == OP_SBC_R | op == OP_SUB_I | op == OP_SBC_I |
                         op == OP_COMPARE;
   wire logic cy_op    = op == OP_ADC_R | op == OP_SBC_R | op == OP_ADC_I | op == OP_SBC_I;
   wire logic [7:0] alu_a  = imm_op ? imm : rv;
   wire logic [7:0] alu_b  = sub_op ? ~work_reg : work_reg;
   wire logic       alu_ci = cy_op ? c_reg : sub_op;
   wire logic [8:0] sum9   = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_ci};
   wire logic [4:0] half5  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_ci};

   // Watchdog expiry
   wire logic wdt_exp = wdt_reg == 32'(WDT_LIMIT - 1);

   // Execution results
   logic [7:0]      x_work, x_res, x_rdata, x_eed, x_eea, x_t0md;
   logic            x_c, x_dc, x_z, x_pd_n, x_to_n, x_gie, x_halt, x_wdt_clr;
   logic            x_rwe, x_fwe, x_swe, x_eewe, x_push, x_pop, x_has_res;
   logic [1:0]      x_unlock, x_cyc;
   logic [PC_W-1:0] x_pc, x_ret;
   logic [8:0]      daa_t;

   always_comb begin
      x_work    = work_reg;
      x_res     = 8'h00;
      x_has_res = 1'b0;
      x_rdata   = 8'h00;
      x_eed     = eed_reg;
      x_eea     = eea_reg;
      x_t0md    = t0md_reg;
      x_c       = c_reg;
      x_dc      = dc_reg;
      x_z       = z_reg;
      x_pd_n    = pd_n_reg;
      x_to_n    = to_n_reg;
      x_gie     = gie_reg;
      x_halt    = 1'b0;
      x_wdt_clr = 1'b0;
      x_rwe     = 1'b0;
      x_fwe     = 1'b0;
      x_swe     = 1'b0;
      x_eewe    = 1'b0;
      x_push    = 1'b0;
      x_pop     = 1'b0;
      x_unlock  = unlock_reg;
      x_cyc     = 2'h0;
      x_pc      = pc_inc;
      x_ret     = pc_inc;
      daa_t     = {1'b0, work_reg};
      case (op)
         OP_AND_R, OP_OR_R, OP_XOR_R, OP_COMPLEMENT: begin
            x_has_res = 1'b1;
            x_res     = op == OP_AND_R ? (work_reg & rv) :
                        op == OP_OR_R  ? (work_reg | rv) :
                        op == OP_XOR_R ? (work_reg ^ rv) : ~rv;
            x_z       = x_res == 8'h00;
         end
         OP_AND_I, OP_OR_I, OP_XOR_I: begin
            x_work = op == OP_AND_I ? (work_reg & imm) :
                     op == OP_OR_I  ? (work_reg | imm) : (work_reg ^ imm);
            x_z    = x_work == 8'h00;
         end
         OP_ROT_RIGHT: begin
            x_has_res = 1'b1;
            x_res     = {c_reg, rv[7:1]};
            x_c       = rv[0];
         end
         OP_ROT_LEFT: begin
            x_has_res = 1'b1;
            x_res     = {rv[6:0], c_reg};
            x_c       = rv[7];
         end
         OP_BIT_SET, OP_BIT_CLEAR: begin
            x_rwe          = 1'b1;
            x_rdata        = rv;
            x_rdata[b_idx] = op == OP_BIT_SET;
         end
         OP_INC, OP_DEC: begin
            x_has_res = 1'b1;
            x_res     = op == OP_INC ? rv + 8'h01 : rv - 8'h01;
            x_z       = x_res == 8'h00;
         end
         OP_SKIP_CLEAR, OP_SKIP_SET: begin
            if (rv[b_idx] == (op == OP_SKIP_SET)) begin
               x_pc  = pc_skip;
               x_cyc = 2'h1;
            end
         end
         OP_INC_SKIP, OP_DEC_SKIP: begin
            x_has_res = 1'b1;
            x_res     = op == OP_INC_SKIP ? rv + 8'h01 : rv - 8'h01;
            if (x_res == 8'h00) begin
               x_pc  = pc_skip;
               x_cyc = 2'h1;
            end
         end
         OP_MOVE_TO_R: begin
            x_rwe   = 1'b1;
            x_rdata = work_reg;
         end
         OP_MOVE_R: begin
            x_has_res = 1'b1;
            x_res     = rv;
            x_z       = rv == 8'h00;
         end
         OP_MOVE_I:     x_work = imm;
         OP_SWAP: begin
            x_has_res = 1'b1;
            x_res     = {rv[3:0], rv[7:4]};
         end
         OP_F_STORE:    x_fwe = f_ok;
         OP_F_LOAD:     x_work = f_ok ? fpage[f_idx] : work_reg;
         OP_S_STORE:    x_swe = s_ok;
         OP_S_LOAD:     x_work = s_ok ? spage[s_idx] : work_reg;
         OP_TIMER_MODE: x_t0md = work_reg;
         OP_ADD_R, OP_SUB_R, OP_ADC_R, OP_SBC_R: begin
            x_has_res = 1'b1;
            x_res     = sum9[7:0];
            x_z       = sum9[7:0] == 8'h00;
            x_dc      = half5[4];
            x_c       = sum9[8];
         end
         OP_ADD_I, OP_SUB_I, OP_ADC_I, OP_SBC_I: begin
            x_work = sum9[7:0];
            x_z    = sum9[7:0] == 8'h00;
            x_dc   = half5[4];
            x_c    = sum9[8];
         end
         OP_COMPARE: begin
            x_z = sum9[7:0] == 8'h00;
            x_c = sum9[8];
         end
         OP_DEC_ADJ: begin
            if (work_reg[3:0] > BCD_MAX || dc_reg)
               daa_t = daa_t + {1'b0, BCD_LO_FIX};
            if (daa_t[8:4] > {1'b0, BCD_MAX} || c_reg) begin
               daa_t = daa_t + {1'b0, BCD_HI_FIX};
               x_c   = 1'b1;
            end
            x_work = daa_t[7:0];
         end
         OP_CLEAR_W: begin
            x_work = 8'h00;
            x_z    = 1'b1;
         end
         OP_CLEAR_R: begin
            x_rwe = 1'b1;
            x_z   = 1'b1;
         end
         OP_HALT: begin
            x_halt    = 1'b1;
            x_pd_n    = 1'b0;
            x_to_n    = 1'b1;
            x_wdt_clr = 1'b1;
         end
         OP_WDT_CLEAR: begin
            x_wdt_clr = 1'b1;
            x_pd_n    = 1'b1;
            x_to_n    = 1'b1;
         end
         OP_INT_ON:     x_gie = 1'b1;
         OP_INT_OFF:    x_gie = 1'b0;
         OP_SOFT_INT: begin
            x_push = 1'b1;
            x_gie  = 1'b0;
            x_pc   = IRQ_VECTOR;
            x_cyc  = 2'h2;
         end
         OP_RETURN, OP_RETURN_INT, OP_RETURN_IMM: begin
            x_pop = 1'b1;
            x_pc  = stack[sp_top];
            x_cyc = 2'h1;
            if (op == OP_RETURN_INT)
               x_gie = 1'b1;
            if (op == OP_RETURN_IMM)
               x_work = imm;
         end
         OP_CALL_W, OP_JUMP_W: begin
            x_push = op == OP_CALL_W;
            x_pc   = {2'b00, work_reg};
            x_cyc  = 2'h1;
         end
         OP_CALL, OP_JUMP: begin
            x_push = op == OP_CALL;
            x_pc   = ins[PC_W-1:0];
            x_cyc  = 2'h1;
         end
         OP_EE_ADDR_RD: x_work = eea_reg;
         OP_EE_ADDR_WR: x_eea  = work_reg;
         OP_EE_DATA_RD: x_work = eed_reg;
         OP_EE_DATA_WR: x_eed  = work_reg;
         OP_EE_READ:    x_eed  = ee_mem[eea_reg[EEA_W-1:0]];
         OP_EE_WRITE: begin
            x_eewe   = unlock_reg == 2'h2;
            x_unlock = 2'h0;
         end
         OP_EE_UNLOCK: begin
            // Serial key: first byte then second; anything else relocks
            x_unlock = (unlock_reg == 2'h0 && work_reg == UNLOCK_KEY0) ? 2'h1 :
                       (unlock_reg == 2'h1 && work_reg == UNLOCK_KEY1) ? 2'h2 :
                       2'h0;
         end
         default: x_pc = pc_inc;
      endcase
      if (x_has_res) begin
         if (d_bit) begin
            x_rwe   = 1'b1;
            x_rdata = x_res;
         end else begin
            x_work = x_res;
         end
      end
   end

   // Control page read mux
   logic [31:0] ctrl_rd;
   always_comb begin
      ctrl_rd = 32'h0000_0000;
      case (bus_idx)
         IDX_INSTR:      ctrl_rd = {16'h0000, ins_reg};
         IDX_WORK:       ctrl_rd = {24'h000000, work_reg};
         IDX_STATUS: begin
            ctrl_rd[ST_CARRY]  = c_reg;
            ctrl_rd[ST_HALF]   = dc_reg;
            ctrl_rd[ST_ZERO]   = z_reg;
            ctrl_rd[ST_PD_N]   = pd_n_reg;
            ctrl_rd[ST_TO_N]   = to_n_reg;
            ctrl_rd[ST_HALT]   = halt_reg;
            ctrl_rd[ST_BUSY]   = busy_reg != 2'h0;
            ctrl_rd[ST_GIE]    = gie_reg;
            ctrl_rd[ST_UNLOCK] = unlock_reg == 2'h2;
         end
         IDX_PC:         ctrl_rd = {22'h000000, pc_reg};
         IDX_EE_ADDR:    ctrl_rd = {24'h000000, eea_reg};
         IDX_EE_DATA:    ctrl_rd = {24'h000000, eed_reg};
         IDX_TIMER_MODE: ctrl_rd = {24'h000000, t0md_reg};
         default:        ctrl_rd = 32'h0000_0000;
      endcase
   end

   wire logic [31:0] bus_rd =
      bus_page == PAGE_CTRL            ? ctrl_rd :
      bus_page == PAGE_R               ? {24'h000000, rpage[bus_idx]} :
      bus_page == PAGE_F  && f_ok_bus  ? {24'h000000, fpage[bus_idx[3:0]]} :
      bus_page == PAGE_S  && s_ok_bus  ? {24'h000000, spage[bus_idx[4:0]]} :
      bus_page == PAGE_EE && ee_ok_bus ? {24'h000000, ee_mem[bus_idx[EEA_W-1:0]]} :
      32'h0000_0000;

   wire logic ctrl_wr = wr_go & bus_page == PAGE_CTRL;
   wire logic wake_go = halt_reg & (wake_in | wdt_exp);
   wire logic wake_irq = halt_reg & wake_in & gie_reg;

   // Bus handshake: one wait cycle, then waitrequest low for one cycle
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg  <= ~bus_go;
         if (bus_go)
            rdata_reg <= avm_read_in ? bus_rd : 32'h0000_0000;
      end
   end

   // Core registers
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         work_reg   <= 8'h00;
         c_reg      <= 1'b0;
         dc_reg     <= 1'b0;
         z_reg      <= 1'b0;
         pd_n_reg   <= 1'b1;
         to_n_reg   <= 1'b1;
         gie_reg    <= 1'b0;
         halt_reg   <= 1'b0;
         pc_reg     <= '0;
         sp_reg     <= '0;
         busy_reg   <= 2'h0;
         ins_reg    <= 16'h0000;
         eea_reg    <= 8'h00;
         eed_reg    <= 8'h00;
         t0md_reg   <= 8'h00;
         unlock_reg <= 2'h0;
      end else if (ins_go) begin
         ins_reg    <= ins;
         work_reg   <= x_work;
         {c_reg, dc_reg, z_reg} <= {x_c, x_dc, x_z};
         pd_n_reg   <= x_pd_n;
         to_n_reg   <= x_to_n;
         gie_reg    <= x_gie;
         halt_reg   <= x_halt;
         pc_reg     <= x_pc;
         sp_reg     <= x_push ? sp_reg + SP_W'(1) : x_pop ? sp_top : sp_reg;
         busy_reg   <= x_cyc;
         eea_reg    <= x_eea;
         eed_reg    <= x_eed;
         t0md_reg   <= x_t0md;
         unlock_reg <= x_unlock;
      end else begin
         if (busy_reg != 2'h0)
            busy_reg <= busy_reg - 2'h1;
         if (wdt_exp)
            to_n_reg <= 1'b0;
         if (wake_go)
            halt_reg <= 1'b0;
         if (wake_irq) begin
            pc_reg  <= IRQ_VECTOR;
            gie_reg <= 1'b0;
            sp_reg  <= sp_reg + SP_W'(1);
         end
         if (ctrl_wr && bus_idx == IDX_WORK)
            work_reg <= avm_writedata_in[7:0];
         if (ctrl_wr && bus_idx == IDX_STATUS)
            {z_reg, dc_reg, c_reg} <= avm_writedata_in[ST_ZERO:ST_CARRY];
         if (ctrl_wr && bus_idx == IDX_EE_ADDR)
            eea_reg <= avm_writedata_in[7:0];
         if (ctrl_wr && bus_idx == IDX_EE_DATA)
            eed_reg <= avm_writedata_in[7:0];
      end
   end

   // Watchdog counter, restarted by clear and halt
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || (ins_go && x_wdt_clr) || wdt_exp)
         wdt_reg <= 32'h0000_0000;
      else
         wdt_reg <= wdt_reg + 32'h0000_0001;
   end

   // Storage arrays
   always_ff @(posedge clk_in) begin
      if (ins_go && x_rwe)
         rpage[r_idx] <= x_rdata;
      else if (wr_go && bus_page == PAGE_R)
         rpage[bus_idx] <= avm_writedata_in[7:0];
      if (ins_go && x_fwe)
         fpage[f_idx] <= work_reg;
      else if (wr_go && bus_page == PAGE_F && f_ok_bus)
         fpage[bus_idx[3:0]] <= avm_writedata_in[7:0];
      if (ins_go && x_swe)
         spage[s_idx] <= work_reg;
      else if (wr_go && bus_page == PAGE_S && s_ok_bus)
         spage[bus_idx[4:0]] <= avm_writedata_in[7:0];
      if (ins_go && x_eewe)
         ee_mem[eea_reg[EEA_W-1:0]] <= eed_reg;
      else if (wr_go && bus_page == PAGE_EE && ee_ok_bus)
         ee_mem[bus_idx[EEA_W-1:0]] <= avm_writedata_in[7:0];
      if (ins_go && x_push)
         stack[sp_reg] <= x_ret;
      else if (!ins_go && wake_irq)
         stack[sp_reg] <= pc_reg;
   end

   // Outputs
   always_ff @(posedge clk_in) begin
      if (sys_rst_in)
         halted_out <= 1'b0;
      else
         halted_out <= ins_go ? x_halt : (halt_reg & ~wake_go);
   end

   assign avm_readdata_out    = rdata_reg;
   assign avm_waitrequest_out = wait_reg;

endmodule

// >>> inc/mcx_pkg.sv
/*
 * Shared constants of the instruction executor: register map, status
 * field positions, opcode enumeration, vectors and EEPROM unlock keys.
 * Assumes a single 50 MHz clock domain and an Avalon-MM register bus.
 */
package mcx_pkg;

   // Clock and watchdog timing
   localparam int          CLK_HZ           = 50_000_000;
   localparam int          WDT_TIMEOUT_MS   = 18;
   localparam int          WDT_CYCLES       = CLK_HZ / 1000 * WDT_TIMEOUT_MS;

   // Bus geometry
   localparam int          ADDR_W           = 12;
   localparam int          PC_W             = 10;

   // Page select, byte address bits 11:8
   localparam logic [3:0]  PAGE_CTRL        = 4'h0;
   localparam logic [3:0]  PAGE_R           = 4'h1;
   localparam logic [3:0]  PAGE_F           = 4'h2;
   localparam logic [3:0]  PAGE_S           = 4'h3;
   localparam logic [3:0]  PAGE_EE          = 4'h4;

   // Control page word index, byte address bits 7:2
   localparam logic [5:0]  IDX_INSTR        = 6'h00;
   localparam logic [5:0]  IDX_WORK         = 6'h01;
   localparam logic [5:0]  IDX_STATUS       = 6'h02;
   localparam logic [5:0]  IDX_PC           = 6'h03;
   localparam logic [5:0]  IDX_EE_ADDR      = 6'h04;
   localparam logic [5:0]  IDX_EE_DATA      = 6'h05;
   localparam logic [5:0]  IDX_TIMER_MODE   = 6'h06;

   // Status word bit positions
   localparam int          ST_CARRY         = 0;
   localparam int          ST_HALF          = 1;
   localparam int          ST_ZERO          = 2;
   localparam int          ST_PD_N          = 3;
   localparam int          ST_TO_N          = 4;
   localparam int          ST_HALT          = 5;
   localparam int          ST_BUSY          = 6;
   localparam int          ST_GIE           = 7;
   localparam int          ST_UNLOCK        = 8;

   // Page limits
   localparam int          R_PAGE_SIZE      = 64;
   localparam logic [3:0]  F_PAGE_LO        = 4'h5;
   localparam logic [3:0]  F_PAGE_HI        = 4'hF;
   localparam int          S_PAGE_SIZE      = 20;

   // Vectors, nibble limit and unlock keys
   localparam logic [PC_W-1:0] IRQ_VECTOR   = 10'h008;
   localparam logic [3:0]  BCD_MAX          = 4'h9;
   localparam logic [7:0]  BCD_LO_FIX       = 8'h06;
   localparam logic [7:0]  BCD_HI_FIX       = 8'h60;
   localparam logic [7:0]  UNLOCK_KEY0      = 8'h55;
   localparam logic [7:0]  UNLOCK_KEY1      = 8'hAA;

   // Opcode field is instruction bits 15:10, order gives the encoding
   typedef enum logic [5:0] {
      OP_AND_R, OP_OR_R, OP_XOR_R, OP_AND_I, OP_OR_I, OP_XOR_I,
      OP_ROT_RIGHT, OP_ROT_LEFT, OP_BIT_SET, OP_BIT_CLEAR, OP_INC, OP_DEC,
      OP_COMPLEMENT, OP_SKIP_CLEAR, OP_SKIP_SET, OP_INC_SKIP, OP_DEC_SKIP,
      OP_MOVE_TO_R, OP_MOVE_R, OP_MOVE_I, OP_SWAP, OP_F_STORE, OP_F_LOAD,
      OP_S_STORE, OP_S_LOAD, OP_TIMER_MODE, OP_ADD_R, OP_SUB_R, OP_ADC_R,
      OP_SBC_R, OP_ADD_I, OP_SUB_I, OP_ADC_I, OP_SBC_I, OP_DEC_ADJ,
      OP_COMPARE, OP_CLEAR_W, OP_CLEAR_R, OP_NOP, OP_HALT, OP_WDT_CLEAR,
      OP_INT_ON, OP_INT_OFF, OP_SOFT_INT, OP_RETURN, OP_RETURN_INT,
      OP_RETURN_IMM, OP_CALL_W, OP_JUMP_W, OP_CALL, OP_JUMP, OP_EE_ADDR_RD,
      OP_EE_ADDR_WR, OP_EE_DATA_RD, OP_EE_DATA_WR, OP_EE_READ, OP_EE_WRITE,
      OP_EE_UNLOCK
   } mcx_op_t;

endpackage

// >>> test/mcx_properties.sv
/* Port assertions of the instruction executor.
   Assumes the bind below and a single clock domain. */
`timescale 1ns/1ps
module mcx_properties
   import mcx_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              sys_rst_in,
   input wire logic [ADDR_W-1:0] avm_address_in,
   input wire logic              avm_read_in,
   input wire logic              avm_write_in,
   input wire logic [31:0]       avm_writedata_in,
   input wire logic [31:0]       avm_readdata_out,
   input wire logic              avm_waitrequest_out,
   input wire logic              wake_in,
   input wire logic              halted_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   wire       instr_w = avm_write_in && avm_address_in[11:2] == 10'h000;
   wire       rd_done = avm_read_in && !avm_waitrequest_out;
   wire [5:0] op      = avm_writedata_in[15:10];
   wire [3:0] page    = avm_address_in[11:8];
   wire [5:0] idx     = avm_address_in[7:2];
   halt_enter_a: assert property (instr_w && !avm_waitrequest_out && op == OP_HALT |-> halted_out)
      else $error("halt not entered");
   halt_cause_a: assert property ($rose(halted_out) |-> $past(instr_w && op == OP_HALT))
      else $error("halt without instruction");
   halt_stall_a: assert property (halted_out && instr_w |=> avm_waitrequest_out)
      else $error("instruction taken in halt");
   wake_resume_a: assert property (halted_out && wake_in |-> ##[1:3] !halted_out)
      else $error("no wake");
   op_finish_a: assert property (instr_w && avm_waitrequest_out && !halted_out |-> ##[1:4] !avm_waitrequest_out)
      else $error("instruction never completes");
   f_range_a: assert property (rd_done && page == PAGE_F && idx < 6'h05 |-> avm_readdata_out == 32'h00000000)
      else $error("secondary page out of range");
   s_range_a: assert property (rd_done && page == PAGE_S && idx > 6'h13 |-> avm_readdata_out == 32'h00000000)
      else $error("third page out of range");
   r_width_a: assert property (rd_done && page == PAGE_R |-> avm_readdata_out[31:8] == 24'h000000)
      else $error("register wider than a byte");
   cover property (halted_out ##1 !halted_out);
   cover property (instr_w && !avm_waitrequest_out);
   cover property (rd_done && page == PAGE_F);
endmodule
bind mcx_executor mcx_properties chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .avm_address_in(avm_address_in), .avm_read_in(avm_read_in), .avm_write_in(avm_write_in),
   .avm_writedata_in(avm_writedata_in), .avm_readdata_out(avm_readdata_out),
   .avm_waitrequest_out(avm_waitrequest_out), .wake_in(wake_in), .halted_out(halted_out));

// >>> test/mcx_wake_model.sv
/* Wake source standing beside the executor.
   Assumes halted_in comes from the design on the same clock. */
`timescale 1ns/1ps
module mcx_wake_model (
   input  wire logic clk_in,
   input  wire logic enable_in,
   input  wire logic halted_in,
   output logic      wake_out = 1'b0
);
   logic [3:0] wait_reg = 4'h0;
   // Late wake, so halt status can be read first
   always_ff @(posedge clk_in) begin
      wait_reg <= halted_in ? wait_reg + 4'h1 : 4'h0;
      wake_out <= enable_in && halted_in && wait_reg > 4'h5;
   end
endmodule

// >>> test/mcx_executor_test.sv
/* Directed bench of the executor over its Avalon-MM port.
   Assumes the wake model and the bound checker. */
`timescale 1ns/1ps
module mcx_executor_test
   import mcx_pkg::*;
;
   logic              clk_in = 1'b0;
   logic              sys_rst_in = 1'b1;
   logic [ADDR_W-1:0] avm_address_in = 12'h000;
   logic              avm_read_in = 1'b0;
   logic              avm_write_in = 1'b0;
   logic [31:0]       avm_writedata_in = 32'h00000000;
   logic [31:0]       avm_readdata_out, rdata;
   logic              avm_waitrequest_out, wake_in, halted_out, wake_en = 1'b0;
   int                err_count = 0;
   int                total_checks = 0;
   // Short watchdog limit keeps the halt tests brief
   mcx_executor #(.WDT_LIMIT(200)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .avm_address_in(avm_address_in), .avm_read_in(avm_read_in),
      .avm_write_in(avm_write_in), .avm_writedata_in(avm_writedata_in),
      .avm_readdata_out(avm_readdata_out), .avm_waitrequest_out(avm_waitrequest_out),
      .wake_in(wake_in), .halted_out(halted_out));
   mcx_wake_model wake (.clk_in(clk_in), .enable_in(wake_en), .halted_in(halted_out),
      .wake_out(wake_in));
   initial forever #10 clk_in = ~clk_in;
   task automatic bus(input logic rd, input logic [11:0] a, input logic [31:0] d);
      avm_address_in   <= a;
      avm_read_in      <= rd;
      avm_write_in     <= !rd;
      avm_writedata_in <= d;
      do @(posedge clk_in); while (avm_waitrequest_out !== 1'b0);
      rdata = avm_readdata_out;
      avm_read_in  <= 1'b0;
      avm_write_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic w(input logic [11:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic x(input mcx_op_t op, input logic [9:0] f);
      bus(1'b0, 12'h000, {16'h0000, op, f});
   endtask
   task automatic c(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      bus(1'b1, a, 32'h00000000);
      total_checks++;
      if ((rdata & m) !== (e & m)) begin
         err_count++;
         $display("mismatch addr %h expected %h seen %h", a, e & m, rdata & m);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #50000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      c(12'h008, 32'h18);
      w(12'h004, 32'h12);
      w(12'h114, 32'h34);
      x(OP_ADD_R, 10'h045);
      c(12'h114, 32'h46);
      c(12'h008, 32'h0, 32'h7);
      x(OP_SUB_R, 10'h005);
      c(12'h004, 32'h34);
      c(12'h008, 32'h3, 32'h7);
      x(OP_ADC_R, 10'h005);
      c(12'h004, 32'h7B);
      x(OP_SBC_R, 10'h045);
      c(12'h114, 32'hCA);
      c(12'h00C, 32'h4);
      w(12'h118, 32'h1);
      x(OP_SKIP_CLEAR, 10'h005);
      x(OP_DEC_SKIP, 10'h046);
      c(12'h118, 32'h0);
      c(12'h00C, 32'h8);
      c(12'h008, 32'h0, 32'h7);
      x(OP_XOR_I, 10'h07B);
      c(12'h008, 32'h4, 32'h7);
      w(12'h004, 32'h20);
      x(OP_JUMP_W, 10'h000);
      c(12'h00C, 32'h20);
      w(12'h004, 32'h30);
      x(OP_CALL_W, 10'h000);
      x(OP_RETURN, 10'h000);
      c(12'h00C, 32'h21);
      w(12'h004, 32'hA5);
      x(OP_F_STORE, 10'h005);
      c(12'h214, 32'hA5);
      c(12'h210, 32'h0);
      w(12'h34C, 32'h3C);
      x(OP_S_LOAD, 10'h013);
      c(12'h004, 32'h3C);
      c(12'h350, 32'h0);
      x(OP_DEC_ADJ, 10'h000);
      c(12'h004, 32'h42);
      x(OP_TIMER_MODE, 10'h000);
      c(12'h018, 32'h42);
      c(12'h01C, 32'h0);
      w(12'h40C, 32'h0);
      w(12'h010, 32'h3);
      w(12'h014, 32'h5C);
      x(OP_EE_WRITE, 10'h000);
      c(12'h40C, 32'h0);
      w(12'h004, 32'h55);
      x(OP_EE_UNLOCK, 10'h000);
      w(12'h004, 32'hAA);
      x(OP_EE_UNLOCK, 10'h000);
      x(OP_EE_WRITE, 10'h000);
      c(12'h40C, 32'h5C);
      w(12'h014, 32'h0);
      x(OP_EE_READ, 10'h000);
      c(12'h014, 32'h5C);
      x(OP_WDT_CLEAR, 10'h000);
      x(OP_HALT, 10'h000);
      c(12'h008, 32'h30, 32'h38);
      while (halted_out !== 1'b0) @(posedge clk_in);
      c(12'h008, 32'h0, 32'h38);
      c(12'h00C, 32'h2C);
      x(OP_WDT_CLEAR, 10'h000);
      c(12'h008, 32'h18, 32'h38);
      x(OP_INT_ON, 10'h000);
      wake_en <= 1'b1;
      x(OP_HALT, 10'h000);
      while (halted_out !== 1'b0) @(posedge clk_in);
      c(12'h00C, 32'h8);
      final_report();
   end
endmodule
